//--- rtl/smc_command_port.v
`timescale 1ns/1ps
`include "smc_defs.vh"
// Operation
// R1: get input header drives 001 on bits 5..3, buffer index below.
// R2: input status 010010, error bits 010110, refresh 010111.
// R3: store input cell drives 100 on bits 5..3, buffer index below.
// R4: load output cell drives 110 on bits 5..3, output index below.
// R5: edit header 111100, edit header with crc 111101.
// R6: output header 111110, with crc 111001, load config 111010.
// R7: no command code outside the defined set is ever issued.
// R8: outside party holds reset input high at least 8 cycles.
// R9: reset done reported 8191 cycles after reset input falls.
// R10: reset output high within 2 cycles of reset input high.
// R11: pacing inputs period at least 3 cycles, phases 1.2 cycles.
// R12: a full input buffer seen in status gets a store scheduled.
// R13: index bits carry buffer number 000 through 111.
// R14: command bus changes only on clock edges, held one full cycle.
module smc_command_port (
  input wire sys_clk,
  input wire rst_b,
  input wire reset_input,
  input wire pacing_input_high_priority,
  input wire pacing_input_second_priority,
  input wire req_valid,
  input wire [3:0] req_kind,
  input wire [2:0] req_index,
  input wire status_valid,
  input wire [7:0] status_full,
  output wire req_ready,
  output reg [5:0] command_bus,
  output reg command_valid,
  output reg reset_output,
  output reg reset_done,
  output reg pacing_high_tick,
  output reg pacing_second_tick
);
  reg [2:0] rin_sync_q;
  reg [2:0] ph_sync_q;
  reg [2:0] ps_sync_q;
  reg [12:0] rst_cnt_q;
  reg [7:0] store_pend_q;
  reg [7:0] store_pend_d;
  reg [5:0] code_d;
  reg code_ok_d;
  reg store_pick_d;
  reg [2:0] store_idx_d;
  integer i;
  // two-flop sync plus one stage for edge detection
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      rin_sync_q <= 3'h0;
      ph_sync_q <= 3'h0;
      ps_sync_q <= 3'h0;
    end else begin
      rin_sync_q <= {rin_sync_q[1:0], reset_input};
      ph_sync_q <= {ph_sync_q[1:0], pacing_input_high_priority};
      ps_sync_q <= {ps_sync_q[1:0], pacing_input_second_priority};
    end
  end
  // pacing falling edges; inputs obeying min period are never missed
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      pacing_high_tick <= 1'b0;
      pacing_second_tick <= 1'b0;
    end else begin
      pacing_high_tick <= ph_sync_q[2] & ~ph_sync_q[1]; // R11
      pacing_second_tick <= ps_sync_q[2] & ~ps_sync_q[1]; // R11
    end
  end
  // reset output follows the synced input; internal reset count on release
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      reset_output <= 1'b1;
      reset_done <= 1'b0;
      rst_cnt_q <= 13'h0;
    end else begin
      // flop after the first stage of the reset synchroniser, so the pin shows within two edges
      reset_output <= rin_sync_q[0]; // R10
      if (rin_sync_q[1]) begin
        rst_cnt_q <= 13'h0;
        reset_done <= 1'b0;
      end else if (rst_cnt_q != `SMC_RESET_PROCESS_CYCLES) begin
        rst_cnt_q <= rst_cnt_q + 13'h1; // R9
      end else begin
        reset_done <= 1'b1; // R9
      end
    end
  end
  // pick lowest pending store
  always @* begin
    store_pick_d = |store_pend_q;
    store_idx_d = 3'h0;
    for (i = 7; i >= 0; i = i - 1) begin
      if (store_pend_q[i]) begin
        store_idx_d = i[2:0]; // R13
      end
    end
  end
  // request decode; unknown kinds are accepted and dropped
  always @* begin
    code_ok_d = 1'b1;
    case (req_kind)
      `SMC_REQ_GET_INPUT_HEADER: code_d = {`SMC_OP_GET_INPUT_HEADER, req_index}; // R1 R13
      `SMC_REQ_GET_INPUT_STATUS: code_d = `SMC_CMD_GET_INPUT_STATUS; // R2
      `SMC_REQ_GET_ERROR_BITS: code_d = `SMC_CMD_GET_ERROR_BITS; // R2
      `SMC_REQ_REFRESH: code_d = `SMC_CMD_REFRESH; // R2
      `SMC_REQ_STORE_INPUT_CELL: code_d = {`SMC_OP_STORE_INPUT_CELL, req_index}; // R3
      `SMC_REQ_LOAD_OUTPUT_CELL: code_d = {`SMC_OP_LOAD_OUTPUT_CELL, req_index}; // R4
      `SMC_REQ_PUT_EDIT_HEADER: code_d = `SMC_CMD_PUT_EDIT_HEADER; // R5
      `SMC_REQ_PUT_EDIT_HEADER_CRC: code_d = `SMC_CMD_PUT_EDIT_HEADER_CRC; // R5
      `SMC_REQ_PUT_OUTPUT_HEADER: code_d = `SMC_CMD_PUT_OUTPUT_HEADER; // R6
      `SMC_REQ_PUT_OUTPUT_HEADER_CRC: code_d = `SMC_CMD_PUT_OUTPUT_HEADER_CRC; // R6
      `SMC_REQ_LOAD_CONFIG_REGISTER: code_d = `SMC_CMD_LOAD_CONFIG_REGISTER; // R6
      default: begin
        code_d = `SMC_CMD_IDLE;
        code_ok_d = 1'b0; // R7
      end
    endcase
  end
  // user requests wait while a scheduled store is pending
  assign req_ready = reset_done & ~store_pick_d;
  // pending stores: status full sets win over the clear of an issued store
  always @* begin
    store_pend_d = store_pend_q;
    if (reset_done && store_pick_d) begin
      store_pend_d[store_idx_d] = 1'b0;
    end
    if (status_valid) begin
      store_pend_d = store_pend_d | status_full; // R12
    end
  end
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      store_pend_q <= 8'h0;
      command_bus <= `SMC_CMD_IDLE;
      command_valid <= 1'b0;
    end else begin
      store_pend_q <= store_pend_d;
      // one code per cycle, registered on the rising edge
      if (reset_done && store_pick_d) begin
        command_bus <= {`SMC_OP_STORE_INPUT_CELL, store_idx_d}; // R12 R14
        command_valid <= 1'b1;
      end else if (req_ready && req_valid && code_ok_d) begin
        command_bus <= code_d; // R14
        command_valid <= 1'b1;
      end else begin
        command_bus <= `SMC_CMD_IDLE;
        command_valid <= 1'b0; // R7
      end
    end
  end
endmodule

//--- rtl/smc_defs.vh
`ifndef SMC_DEFS_VH
`define SMC_DEFS_VH
// command bus codes, 6 bits
`define SMC_OP_GET_INPUT_HEADER 3'h1
`define SMC_OP_STORE_INPUT_CELL 3'h4
`define SMC_OP_LOAD_OUTPUT_CELL 3'h6
`define SMC_CMD_GET_INPUT_STATUS 6'h12
`define SMC_CMD_GET_ERROR_BITS 6'h16
`define SMC_CMD_REFRESH 6'h17
`define SMC_CMD_PUT_EDIT_HEADER 6'h3C
`define SMC_CMD_PUT_EDIT_HEADER_CRC 6'h3D
`define SMC_CMD_PUT_OUTPUT_HEADER 6'h3E
`define SMC_CMD_PUT_OUTPUT_HEADER_CRC 6'h39
`define SMC_CMD_LOAD_CONFIG_REGISTER 6'h3A
`define SMC_CMD_IDLE 6'h00
// request kinds on the user port
`define SMC_REQ_GET_INPUT_HEADER 4'h0
`define SMC_REQ_GET_INPUT_STATUS 4'h1
`define SMC_REQ_GET_ERROR_BITS 4'h2
`define SMC_REQ_STORE_INPUT_CELL 4'h3
`define SMC_REQ_LOAD_OUTPUT_CELL 4'h4
`define SMC_REQ_PUT_EDIT_HEADER 4'h5
`define SMC_REQ_PUT_EDIT_HEADER_CRC 4'h6
`define SMC_REQ_REFRESH 4'h7
`define SMC_REQ_LOAD_CONFIG_REGISTER 4'h8
`define SMC_REQ_PUT_OUTPUT_HEADER 4'h9
`define SMC_REQ_PUT_OUTPUT_HEADER_CRC 4'hA
// reset timing, in system clock cycles
`define SMC_RESET_HOLD_CYCLES 4'h8
`define SMC_RESET_PROCESS_CYCLES 13'h1FFF
`endif

//--- testbench/smc_mem_model.sv
`timescale 1ns/1ps
module smc_mem_model (input sys_clk, command_valid, input [5:0] command_bus,
  output reg status_valid = 1'b0, output reg [7:0] status_full = 8'h00);
  // status answer one cycle after the fetch, buffers 2 and 5 full; bus churns otherwise
  always @(posedge sys_clk) begin
    status_valid <= command_valid && command_bus == 6'h12;
    status_full <= (command_valid && command_bus == 6'h12) ? 8'h24 : ~status_full;
  end
endmodule

//--- testbench/smc_chk.sv
`timescale 1ns/1ps
module smc_chk (input sys_clk, rst_b, reset_input, req_valid, req_ready, status_valid,
  command_valid, reset_output, reset_done, input [3:0] req_kind, input [2:0] req_index,
  input [7:0] status_full, input [5:0] command_bus);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire tk = req_valid & req_ready;
  AST_HDR: assert property (tk&&req_kind==4'h0 |=> command_bus=={3'h1,$past(req_index)})
    else $error("hd");
  AST_LOAD: assert property (tk&&req_kind==4'h4 |=> command_bus=={3'h6,$past(req_index)})
    else $error("ld");
  AST_STAT: assert property (tk&&req_kind==4'h1 |=> command_bus==6'h12) else $error("st");
  AST_CFG: assert property (tk&&req_kind==4'h8 |=> command_bus==6'h3A) else $error("cf");
  AST_RDY: assert property (!reset_done |-> !req_ready) else $error("rd");
  AST_RSTO: assert property ($rose(reset_input) |-> ##[0:2] reset_output) else $error("ro");
  AST_SCHED: assert property (status_valid&&status_full!=8'h00 |=> !req_ready ##1
    (command_valid&&command_bus[5:3]==3'h4)) else $error("sc");
  AST_SET: assert property (command_valid |-> command_bus[5:3] inside {3'h1,3'h4,3'h6} ||
    command_bus inside {6'h12,6'h16,6'h17,6'h3C,6'h3D,6'h3E,6'h39,6'h3A}) else $error("cd");
endmodule
bind smc_command_port smc_chk u_smc_chk (.*);

//--- testbench/smc_command_port_tb.sv
`timescale 1ns/1ps
module smc_command_port_tb;
  reg sys_clk = 1'b0, rst_b = 1'b0, reset_input = 1'b0, req_valid = 1'b0;
  reg [3:0] req_kind = 4'h0;
  reg [2:0] req_index = 3'h0;
  reg ph = 1'b0, ps = 1'b0;
  wire pacing_high_tick, pacing_second_tick;
  wire req_ready, command_valid, reset_output, reset_done, status_valid;
  wire [5:0] command_bus;
  wire [7:0] status_full;
  integer failures = 0, n_checks = 0, i;
  reg [5:0] tab [0:11] = '{6'h0F,6'h12,6'h16,6'h27,6'h30,6'h3C,6'h3D,6'h17,6'h3A,6'h3E,6'h39,6'h00};
  smc_command_port u_smc_command_port (.*, .pacing_input_high_priority(ph),
    .pacing_input_second_priority(ps));
  smc_mem_model u_smc_mem_model (.*);
  initial forever #5 sys_clk = ~sys_clk;
  task chk(input string nm, input logic [5:0] e, s);
    n_checks++;
    if (s !== e) failures++;
    if (s !== e) $display("Error %s exp %h got %h", nm, e, s);
  endtask
  task end_sim;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task t_boot;
    repeat (8100) @(negedge sys_clk);
    chk("early", 6'h00, {5'h00, reset_done});
    repeat (300) @(negedge sys_clk);
    chk("done", 6'h01, {5'h00, reset_done});
  endtask
  task cmd(input logic [3:0] k, input logic [2:0] x);
    @(posedge sys_clk) {req_valid, req_kind, req_index} <= {1'b1, k, x};
    @(negedge sys_clk);
    while (!req_ready) @(negedge sys_clk);
    @(posedge sys_clk) req_valid <= 1'b0;
    @(negedge sys_clk);
  endtask
  task t_pace;
    @(posedge sys_clk) {ph, ps} <= 2'b11;
    repeat (4) @(posedge sys_clk);
    {ph, ps} <= 2'b00;
    repeat (3) @(negedge sys_clk);
    chk("tick_early", 6'h00, {4'h0, pacing_high_tick, pacing_second_tick});
    @(negedge sys_clk);
    chk("tick", 6'h03, {4'h0, pacing_high_tick, pacing_second_tick});
    @(negedge sys_clk);
    chk("tick_end", 6'h00, {4'h0, pacing_high_tick, pacing_second_tick});
  endtask
  task t_codes;
    for (i = 0; i < 12; i++) begin
      cmd(i[3:0], (i == 4) ? 3'h0 : 3'h7);
      chk("code", tab[i], command_bus);
    end
  endtask
  task t_sched;
    cmd(4'h1, 3'h0);
    repeat (3) @(negedge sys_clk);
    chk("st2", 6'h22, command_bus);
    for (i = 0; i < 4 && command_bus !== 6'h25; i++) @(negedge sys_clk);
    chk("st5", 6'h25, command_bus);
  endtask
  task t_rsto;
    @(posedge sys_clk) reset_input <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk("rsto", 6'h01, {5'h00, reset_output});
    repeat (6) @(posedge sys_clk);
    #1 chk("rdrop", 6'h00, {5'h00, reset_done});
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_boot();
    t_codes();
    t_sched();
    t_pace();
    t_rsto();
    end_sim();
  end
  initial begin
    #400000 failures++;
    end_sim();
  end
endmodule
